/* File: common/fhcc_pkg.sv */
/*
  Shared types and constants of the fronthaul copy and combine block.
  Assumes a single clock domain and a classic Wishbone register slave.
*/
package fhcc_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_DL_CELL  = 8'h04;
  localparam logic [7:0] REG_UL_CELL  = 8'h08;
  localparam logic [7:0] REG_DEADLINE = 8'h0c;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_TIMEOUTS = 8'h14;
  localparam logic [7:0] REG_CELL_MAP = 8'h20;

  // ==========================================================
  // Field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_CHAIN_BIT = 1;
  localparam int CTRL_COMP_BIT  = 2;

  // ==========================================================
  // Reset values
  localparam logic [2:0]  CTRL_RST     = 3'h1;
  localparam logic [31:0] DEADLINE_RST = 32'h0000_1000;

  // ==========================================================
  // Widths
  localparam int CELL_W = 4;
  localparam int IDX_W  = 8;
  localparam int SMP_W  = 16;
  localparam int EXP_W  = 4;
  localparam int SEQ_W  = 8;

  // ==========================================================
  // Resource element key
  typedef struct packed {
    logic [15:0] pcid;
    logic        data_dir;
    logic [7:0]  frame_id;
    logic [3:0]  subframe_id;
    logic [5:0]  slot_id;
    logic [5:0]  symbol_id;
    logic        rb;
    logic        sym_inc;
    logic [9:0]  start_prbu;
    logic [7:0]  num_prbu;
  } fhcc_key_t;

  // Downlink message beat, passed through untouched
  typedef struct packed {
    logic [31:0] data;
    logic        sop;
    logic        eop;
  } fhcc_dl_beat_t;

  // Uplink sample beat after transport parsing
  typedef struct packed {
    fhcc_key_t              key;
    logic [EXP_W-1:0]       exp;
    logic [IDX_W-1:0]       idx;
    logic                   last;
    logic signed [SMP_W-1:0] i_smp;
    logic signed [SMP_W-1:0] q_smp;
  } fhcc_ul_beat_t;

  // Combined uplink beat toward the north
  typedef struct packed {
    fhcc_key_t              key;
    logic [SEQ_W-1:0]       seq_id;
    logic [EXP_W-1:0]       exp;
    logic [IDX_W-1:0]       idx;
    logic                   sop;
    logic                   eop;
    logic signed [SMP_W-1:0] i_smp;
    logic signed [SMP_W-1:0] q_smp;
  } fhcc_ul_out_t;

endpackage

/* File: core/fhcc_core.sv */
/*
  Copy and combine core: downlink replication to south ports, uplink
  sample matching, combining, saturation and re-headering, Wishbone regs.
  Assumes parsed message beats arrive on synchronous valid/ready streams.
*/
// The address map and register access over Wishbone were left to the implementer.
// Contract
// - Downlink messages resent unchanged to cell ports
// - Copy targets come only from configuration
// - Copy only to ports of that cell
// - Chained unit forwards downlink south unchanged
// - Gather same-element samples from each port
// - Match on all ten header fields
// - Reassemble fragments before combining
// - Sum I and Q, decompress then recompress
// - Saturate overflow, never wrap
// - Output keeps contributors' compression format
// - Combine every contributor, no selection
// - New own sequence id, other fields copied
// - Uplink combines only ports of that cell
// - Chained unit adds own air samples
// - Chained sum per component with recompression
// - Chained unit reassembles south fragments
// - Chained output keeps south format
// - Chained unit owns its sequence id
// - Chained result goes toward north
// - North neighbour is next unit or DU
`timescale 1ns/100ps
module fhcc_core
  import fhcc_pkg::*;
#(
  parameter int N_PORTS = 4,
  parameter int DEPTH   = 256
)(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  input  wire fhcc_pkg::fhcc_dl_beat_t north_dl_i,
  input  wire logic                 north_dl_valid_i,
  output logic                      north_dl_ready_o,
  output fhcc_pkg::fhcc_dl_beat_t   south_dl_o,
  output logic [N_PORTS-1:0]        south_dl_valid_o,
  input  wire logic [N_PORTS-1:0]   south_dl_ready_i,
  input  wire fhcc_pkg::fhcc_ul_beat_t south_ul_i [N_PORTS],
  input  wire logic [N_PORTS-1:0]   south_ul_valid_i,
  output logic [N_PORTS-1:0]        south_ul_ready_o,
  input  wire fhcc_pkg::fhcc_ul_beat_t air_ul_i,
  input  wire logic                 air_ul_valid_i,
  output logic                      air_ul_ready_o,
  output fhcc_pkg::fhcc_ul_out_t    north_ul_o,
  output logic                      north_ul_valid_o,
  input  wire logic                 north_ul_ready_i
);

  localparam int NC    = N_PORTS + 1;
  localparam int ACC_W = SMP_W + 16 + $clog2(NC) + 1;

  if (N_PORTS < 1 || N_PORTS > 16)
    $error("N_PORTS must be 1 to 16");
  if (DEPTH < 1 || DEPTH > (1 << IDX_W))
    $error("DEPTH must fit the sample index");

  typedef enum {ST_IDLE, ST_COLLECT, ST_EMIT} fhcc_state_t;

  // ==========================================================
  // Register file
  logic [2:0]              ctrl_q;
  logic [CELL_W-1:0]       dl_cell_q;
  logic [CELL_W-1:0]       ul_cell_q;
  logic [31:0]             deadline_q;
  logic [31:0]             timeouts_q;
  logic [CELL_W-1:0]       cell_map_q [N_PORTS];
  logic [SEQ_W-1:0]        seq_q;
  fhcc_state_t             state_q;
  logic                    wb_req;
  logic                    wr_lo;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lo  = wb_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q     <= CTRL_RST;
      dl_cell_q  <= '0;
      ul_cell_q  <= '0;
      deadline_q <= DEADLINE_RST;
    end
    else if (wb_req && wb_we_i)
    begin
      if (wb_adr_i == REG_CTRL && wb_sel_i[0])
        ctrl_q <= wb_dat_i[2:0];
      else if (wb_adr_i == REG_DL_CELL && wb_sel_i[0])
        dl_cell_q <= wb_dat_i[CELL_W-1:0];
      else if (wb_adr_i == REG_UL_CELL && wb_sel_i[0])
        ul_cell_q <= wb_dat_i[CELL_W-1:0];
      else if (wb_adr_i == REG_DEADLINE)
      begin
        for (int b = 0; b < 4; b++)
          if (wb_sel_i[b])
            deadline_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      end
    end
  end

  // Per-port cell membership
  for (genvar p = 0; p < N_PORTS; p++)
  begin : g_map
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        cell_map_q[p] <= '0;
      else if (wr_lo && wb_adr_i == REG_CELL_MAP + 8'(4 * p))
        cell_map_q[p] <= wb_dat_i[CELL_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= '0;
    else if (wb_req)
    begin
      wb_dat_o <= '0;
      if (wb_adr_i == REG_CTRL)
        wb_dat_o <= {29'h0, ctrl_q};
      else if (wb_adr_i == REG_DL_CELL)
        wb_dat_o <= {{(32-CELL_W){1'b0}}, dl_cell_q};
      else if (wb_adr_i == REG_UL_CELL)
        wb_dat_o <= {{(32-CELL_W){1'b0}}, ul_cell_q};
      else if (wb_adr_i == REG_DEADLINE)
        wb_dat_o <= deadline_q;
      else if (wb_adr_i == REG_STATUS)
        wb_dat_o <= {22'h0, 2'(state_q), seq_q};
      else if (wb_adr_i == REG_TIMEOUTS)
        wb_dat_o <= timeouts_q;
      else
        for (int p = 0; p < N_PORTS; p++)
          if (wb_adr_i == REG_CELL_MAP + 8'(4 * p))
            wb_dat_o <= {{(32-CELL_W){1'b0}}, cell_map_q[p]};
    end
  end

  logic enable;
  logic chain_mode;
  logic comp_en;
  assign enable     = ctrl_q[CTRL_EN_BIT];
  assign chain_mode = ctrl_q[CTRL_CHAIN_BIT];
  assign comp_en    = ctrl_q[CTRL_COMP_BIT];

  // ==========================================================
  // Downlink copy
  logic [N_PORTS-1:0] dl_dest;
  logic [N_PORTS-1:0] dl_pend_q;
  logic               dl_load;

  always_comb
  begin
    dl_dest = '0;
    if (chain_mode)
      dl_dest[0] = 1'b1;
    else
      for (int p = 0; p < N_PORTS; p++)
        dl_dest[p] = (cell_map_q[p] == dl_cell_q);
  end

  assign north_dl_ready_o = enable && ((dl_pend_q & ~south_dl_ready_i) == '0);
  assign dl_load          = north_dl_ready_o && north_dl_valid_i;
  assign south_dl_valid_o = dl_pend_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dl_pend_q <= '0;
    else if (dl_load)
      dl_pend_q <= dl_dest;
    else
      dl_pend_q <= dl_pend_q & ~south_dl_ready_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      south_dl_o <= '0;
    else if (dl_load)
      south_dl_o <= north_dl_i;
  end

  // ==========================================================
  // Uplink contributors (south ports, then air)
  fhcc_ul_beat_t      cin   [NC];
  logic [NC-1:0]      cvld;
  logic [NC-1:0]      need;
  logic [NC-1:0]      done_q;
  logic [NC-1:0]      take;
  logic [NC-1:0]      match;
  fhcc_key_t          key_q;
  logic               key_ok_q;
  logic [EXP_W-1:0]   exp_q;
  logic [IDX_W-1:0]   len_q;
  logic [31:0]        timer_q;
  logic [IDX_W-1:0]   out_idx_q;
  logic signed [ACC_W-1:0] acc_i_q [DEPTH];
  logic signed [ACC_W-1:0] acc_q_q [DEPTH];
  int                 sel;
  logic               all_in;
  logic               expired;

  always_comb
  begin
    for (int p = 0; p < N_PORTS; p++)
    begin
      cin[p]  = south_ul_i[p];
      cvld[p] = south_ul_valid_i[p];
    end
    cin[N_PORTS]     = air_ul_i;
    cin[N_PORTS].exp = '0;
    cvld[N_PORTS]    = air_ul_valid_i;
  end

  always_comb
  begin
    need = '0;
    if (chain_mode)
      need = NC'(1) | (NC'(1) << N_PORTS);
    else
      for (int p = 0; p < N_PORTS; p++)
        need[p] = (cell_map_q[p] == ul_cell_q);
  end

  // Key match on every field of the element
  always_comb
  begin
    for (int c = 0; c < NC; c++)
      match[c] = !key_ok_q || (cin[c].key == key_q);
  end

  // Lowest eligible contributor takes the slot this cycle
  always_comb
  begin
    sel  = -1;
    take = '0;
    if (state_q == ST_COLLECT)
      for (int c = NC - 1; c >= 0; c--)
        if (cvld[c] && need[c] && !done_q[c] && match[c])
          sel = c;
    if (sel >= 0)
      take[sel] = 1'b1;
  end

  assign south_ul_ready_o = take[N_PORTS-1:0];
  assign air_ul_ready_o   = take[N_PORTS];
  assign all_in           = ((need & ~done_q) == '0);
  assign expired          = (timer_q >= deadline_q);

  // ==========================================================
  // Uplink state machine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= ST_IDLE;
    else
      case (state_q)
        ST_IDLE:
          if (enable && (cvld & need) != '0)
            state_q <= ST_COLLECT;
        ST_COLLECT:
          if (key_ok_q && (all_in || expired))
            state_q <= ST_EMIT;
        ST_EMIT:
          if (north_ul_ready_i && out_idx_q == len_q)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
  end

  // Header capture, fragment completion, deadline
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q == ST_IDLE)
    begin
      key_q    <= '0;
      key_ok_q <= 1'b0;
      exp_q    <= '0;
      len_q    <= '0;
      done_q   <= '0;
      timer_q  <= '0;
    end
    else if (state_q == ST_COLLECT)
    begin
      timer_q <= timer_q + 32'h1;
      if (sel >= 0)
      begin
        key_q    <= cin[sel].key;
        key_ok_q <= 1'b1;
        if (sel < N_PORTS && comp_en && cin[sel].exp > exp_q)
          exp_q <= cin[sel].exp;
        if (cin[sel].idx > len_q)
          len_q <= cin[sel].idx;
        if (cin[sel].last)
          done_q[sel] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timeouts_q <= '0;
    else if (state_q == ST_COLLECT && key_ok_q && !all_in && expired)
      timeouts_q <= timeouts_q + 32'h1;
  end

  // Accumulators, cleared per element, added by sample index
  for (genvar e = 0; e < DEPTH; e++)
  begin : g_acc
    always_ff @(posedge clk_i)
    begin
      if (rst_i || state_q == ST_IDLE)
      begin
        acc_i_q[e] <= '0;
        acc_q_q[e] <= '0;
      end
      else if (sel >= 0 && cin[sel].idx == IDX_W'(e))
      begin
        acc_i_q[e] <= acc_i_q[e] + (ACC_W'(cin[sel].i_smp)
                      <<< (comp_en ? cin[sel].exp : '0));
        acc_q_q[e] <= acc_q_q[e] + (ACC_W'(cin[sel].q_smp)
                      <<< (comp_en ? cin[sel].exp : '0));
      end
    end
  end

  // ==========================================================
  // Recompression with saturation
  function automatic logic signed [SMP_W-1:0] fhcc_clamp
    (input logic signed [ACC_W-1:0] v, input logic [EXP_W-1:0] sh);
    logic signed [ACC_W-1:0] s, hi, lo;
    s  = v >>> sh;
    hi = {{(ACC_W-SMP_W+1){1'b0}}, {(SMP_W-1){1'b1}}};
    lo = ~hi;
    if (s > hi)
      fhcc_clamp = {1'b0, {(SMP_W-1){1'b1}}};
    else if (s < lo)
      fhcc_clamp = {1'b1, {(SMP_W-1){1'b0}}};
    else
      fhcc_clamp = s[SMP_W-1:0];
  endfunction

  logic emit_step;
  assign emit_step        = state_q == ST_EMIT && north_ul_ready_i;
  assign north_ul_valid_o = state_q == ST_EMIT;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != ST_EMIT)
      out_idx_q <= '0;
    else if (emit_step)
      out_idx_q <= out_idx_q + IDX_W'(1);
  end

  // Own sequence number per combined message
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      seq_q <= '0;
    else if (emit_step && out_idx_q == len_q)
      seq_q <= seq_q + SEQ_W'(1);
  end

  // Output beat toward the north node or distributed unit
  always_comb
  begin
    north_ul_o        = '0;
    north_ul_o.key    = key_q;
    north_ul_o.seq_id = seq_q;
    north_ul_o.exp    = exp_q;
    north_ul_o.idx    = out_idx_q;
    north_ul_o.sop    = out_idx_q == '0;
    north_ul_o.eop    = out_idx_q == len_q;
    north_ul_o.i_smp  = fhcc_clamp(acc_i_q[out_idx_q], exp_q);
    north_ul_o.q_smp  = fhcc_clamp(acc_q_q[out_idx_q], exp_q);
  end

endmodule

/* File: tb/fhcc_monitor.sv */
/*
  Port checker for the copy and combine core.
  Bound to fhcc_core from tb_top; sees top ports only.
*/
`timescale 1ns/100ps
module fhcc_monitor
  import fhcc_pkg::*;
#(
  parameter int N_PORTS = 4
)(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  input wire fhcc_pkg::fhcc_dl_beat_t north_dl_i,
  input wire logic                 north_dl_valid_i,
  input wire logic                 north_dl_ready_o,
  input wire fhcc_pkg::fhcc_dl_beat_t south_dl_o,
  input wire logic [N_PORTS-1:0]   south_dl_valid_o,
  input wire logic [N_PORTS-1:0]   south_dl_ready_i,
  input wire logic [N_PORTS-1:0]   south_ul_ready_o,
  input wire fhcc_pkg::fhcc_ul_out_t north_ul_o,
  input wire logic                 north_ul_valid_o,
  input wire logic                 north_ul_ready_i
);
  import fhcc_pkg::*;
  wire              dl_hs  = north_dl_valid_i && north_dl_ready_o;
  wire              dl_blk = |(south_dl_valid_o & ~south_dl_ready_i);
  wire              ul_end = north_ul_valid_o && north_ul_ready_i
                             && north_ul_o.eop;
  logic [SEQ_W-1:0] seq_q;
  logic             have_q;

  // ====================
  // Last sequence id sent
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      have_q <= 1'b0;
    else if (ul_end)
      have_q <= 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    if (ul_end)
      seq_q <= north_ul_o.seq_id;
  end

  // ====================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack one cycle after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held beyond one cycle");
  property p_dl_copy;
    dl_hs |=> south_dl_o == $past(north_dl_i);
  endproperty
  a_dl_copy: assert property (p_dl_copy)
    else $error("downlink beat altered");
  property p_dl_stall;
    dl_blk |-> !north_dl_ready_o;
  endproperty
  a_dl_stall: assert property (p_dl_stall)
    else $error("north accepted while a port pending");
  property p_dl_hold;
    dl_blk |=> $stable(south_dl_o);
  endproperty
  a_dl_hold: assert property (p_dl_hold)
    else $error("south beat changed while pending");
  property p_ul_grant;
    $onehot0(south_ul_ready_o);
  endproperty
  a_ul_grant: assert property (p_ul_grant)
    else $error("more than one uplink grant");
  property p_ul_hold;
    north_ul_valid_o && !north_ul_ready_i
      |=> north_ul_valid_o && $stable(north_ul_o);
  endproperty
  a_ul_hold: assert property (p_ul_hold)
    else $error("combined beat dropped or changed");
  property p_seq_step;
    north_ul_valid_o && north_ul_o.sop && have_q
      |-> north_ul_o.seq_id == seq_q + 8'h01;
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("sequence id not stepped by one");
  property p_sop_idx;
    north_ul_valid_o && north_ul_o.sop |-> north_ul_o.idx == 8'h00;
  endproperty
  a_sop_idx: assert property (p_sop_idx)
    else $error("message start not at sample zero");
  c_dl_hs: cover property (dl_hs);
  c_dl_blk: cover property (dl_blk);
  c_ul_end: cover property (ul_end);
endmodule

/* File: tb/fhcc_ru_model.sv */
/*
  Radio unit side model: south ports plus air samples.
  Sinks copied downlink with stalls, sends uplink on request.
*/
`timescale 1ns/100ps
module fhcc_ru_model
  import fhcc_pkg::*;
#(
  parameter int N_PORTS = 2
)(
  input wire logic                 clk_i,
  input wire fhcc_pkg::fhcc_dl_beat_t dl_i,
  input wire logic [N_PORTS-1:0]   dl_valid_i,
  output logic [N_PORTS-1:0]       dl_ready_o,
  output fhcc_pkg::fhcc_ul_beat_t  ul_o [N_PORTS],
  output logic [N_PORTS-1:0]       ul_valid_o,
  input wire logic [N_PORTS-1:0]   ul_ready_i,
  output fhcc_pkg::fhcc_ul_beat_t  air_o,
  output logic                     air_valid_o,
  input wire logic                 air_ready_i
);
  import fhcc_pkg::*;
  fhcc_ul_beat_t    ul_q [N_PORTS+1];
  logic [N_PORTS:0] v_q;
  logic             tog_q;
  fhcc_dl_beat_t    dl_got [N_PORTS][16];
  int               dl_n [N_PORTS];
  wire [N_PORTS:0]  rdy = {air_ready_i, ul_ready_i};

  initial
  begin
    v_q = '0;
    tog_q = 1'b0;
    dl_ready_o = '0;
    for (int p = 0; p <= N_PORTS; p++)
      ul_q[p] = '0;
    for (int p = 0; p < N_PORTS; p++)
      dl_n[p] = 0;
  end
  always_comb
    for (int p = 0; p < N_PORTS; p++)
      ul_o[p] = ul_q[p];
  assign air_o       = ul_q[N_PORTS];
  assign ul_valid_o  = v_q[N_PORTS-1:0];
  assign air_valid_o = v_q[N_PORTS];

  // ====================
  // Downlink sink, upper ports stall
  always @(posedge clk_i)
  begin
    tog_q <= ~tog_q;
    for (int p = 0; p < N_PORTS; p++)
      dl_ready_o[p] <= (p == 0) || tog_q;
  end
  always @(negedge clk_i)
    for (int p = 0; p < N_PORTS; p++)
      if (dl_valid_i[p] && dl_ready_o[p] && dl_n[p] < 16)
      begin
        dl_got[p][dl_n[p]] = dl_i;
        dl_n[p]++;
      end

  // ====================
  // Four-sample message, optional mid gap
  task automatic send(input int p, input fhcc_key_t k,
                      input logic [3:0] e, input logic [15:0] i, q,
                      input bit frag);
    fhcc_ul_beat_t b;
    for (int j = 0; j < 4; j++)
    begin
      @(posedge clk_i);
      if (frag && j == 2)
      begin
        v_q[p] <= 1'b0;
        ul_q[p] <= ~ul_q[p];
        repeat (3) @(posedge clk_i);
      end
      b = '{key: k, exp: e, idx: j[7:0], last: (j == 3),
            i_smp: i, q_smp: q};
      ul_q[p] <= b;
      v_q[p] <= 1'b1;
      do @(negedge clk_i); while (rdy[p] !== 1'b1);
    end
    @(posedge clk_i);
    v_q[p] <= 1'b0;
    ul_q[p] <= ~ul_q[p];
  endtask
endmodule

/* File: tb/tb_top.sv */
/*
  Self-checking bench: Wishbone setup, downlink copy, uplink combine.
  Uses fhcc_ru_model on the south side; sinks north with stalls.
*/
`timescale 1ns/100ps
module tb_top;
  import fhcc_pkg::*;
  localparam int NP = 2;
  logic          clk_i, rst_i, cyc, stb, we, ack, n_dl_v, n_dl_r;
  logic          a_v, a_r, n_v, n_r;
  logic [7:0]    adr;
  logic [3:0]    sel;
  logic [31:0]   wdat, wb_dat, rd;
  logic [NP-1:0] s_dl_v, s_dl_r, s_ul_v, s_ul_r;
  fhcc_dl_beat_t n_dl, s_dl;
  fhcc_ul_beat_t s_ul [NP];
  fhcc_ul_beat_t a_ul;
  fhcc_ul_out_t  n_ul;
  fhcc_ul_out_t  ul_got [32];
  int            ul_n, err_count, total_checks, cyc_n, t, m;

  fhcc_core #(.N_PORTS(NP), .DEPTH(256)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat), .wb_ack_o(ack), .north_dl_i(n_dl),
    .north_dl_valid_i(n_dl_v), .north_dl_ready_o(n_dl_r),
    .south_dl_o(s_dl), .south_dl_valid_o(s_dl_v),
    .south_dl_ready_i(s_dl_r), .south_ul_i(s_ul),
    .south_ul_valid_i(s_ul_v), .south_ul_ready_o(s_ul_r),
    .air_ul_i(a_ul), .air_ul_valid_i(a_v), .air_ul_ready_o(a_r),
    .north_ul_o(n_ul), .north_ul_valid_o(n_v), .north_ul_ready_i(n_r));
  fhcc_ru_model #(.N_PORTS(NP)) ru (
    .clk_i(clk_i), .dl_i(s_dl), .dl_valid_i(s_dl_v),
    .dl_ready_o(s_dl_r), .ul_o(s_ul), .ul_valid_o(s_ul_v),
    .ul_ready_i(s_ul_r), .air_o(a_ul), .air_valid_o(a_v),
    .air_ready_i(a_r));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ====================
  // Watchdog and north sink
  always @(posedge clk_i)
  begin
    cyc_n++;
    n_r <= (cyc_n % 4) != 0;
    if (cyc_n == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  always @(negedge clk_i)
    if (n_v && n_r && ul_n < 32)
    begin
      ul_got[ul_n] = n_ul;
      ul_n++;
    end

  // ====================
  // Tasks
  task automatic chk(input logic [63:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  function automatic fhcc_key_t key_of(input logic [7:0] f,
                                       input logic [5:0] s);
    key_of = '{pcid: 16'h0a01, data_dir: 1'b0, frame_id: f,
               subframe_id: 4'h3, slot_id: 6'h05, symbol_id: s,
               rb: 1'b0, sym_inc: 1'b1, start_prbu: 10'h010,
               num_prbu: 8'h04};
  endfunction
  task automatic dl_case(input logic [31:0] ctrl, m1,
                         input logic [1:0] mask);
    int b [NP];
    wb(1'b1, REG_CTRL, ctrl);
    wb(1'b1, REG_CELL_MAP + 8'h04, m1);
    for (int p = 0; p < NP; p++)
      b[p] = ru.dl_n[p];
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk_i);
      n_dl <= '{data: 32'hd0 + k, sop: (k == 0), eop: (k == 2)};
      n_dl_v <= 1'b1;
      do @(negedge clk_i); while (n_dl_r !== 1'b1);
      @(posedge clk_i);
      n_dl_v <= 1'b0;
      n_dl <= ~n_dl;
    end
    do @(negedge clk_i); while (s_dl_v !== 2'b00);
    for (int p = 0; p < NP; p++)
    begin
      chk(ru.dl_n[p] - b[p], mask[p] ? 3 : 0);
      for (int k = 0; k < 3 && mask[p]; k++)
        chk(ru.dl_got[p][b[p]+k], {32'hd0 + k, k == 0, k == 2});
    end
  endtask
  task automatic chk_msg(input int m, input fhcc_key_t k,
                         input logic [15:0] ei, eq, input logic [3:0] ee);
    fhcc_ul_out_t b;
    for (int j = 0; j < 4; j++)
    begin
      b = ul_got[4*m+j];
      chk(b.key, k);
      chk({b.i_smp, b.q_smp}, {ei, eq});
      chk({b.exp, b.idx, b.sop, b.eop}, {ee, j[7:0], j == 0, j == 3});
      chk(b.seq_id, SEQ_W'(ul_got[0].seq_id + m));
    end
  endtask
  task automatic ul_case(input logic [31:0] ctrl, m1, input int o,
                         input logic [3:0] e0, e1,
                         input logic [15:0] i0, i1, q0, q1, ei, eq,
                         input logic [3:0] ee, input logic [7:0] f);
    wb(1'b1, REG_CTRL, ctrl);
    wb(1'b1, REG_CELL_MAP + 8'h04, m1);
    m = ul_n / 4;
    fork
      ru.send(0, key_of(f, 6'h1), e0, i0, q0, 1'b0);
      if (o > 0) ru.send(o == 2 ? NP : 1, key_of(f, 6'h1), e1, i1, q1, o == 1);
    join
    while (ul_n < 4 * m + 4) @(posedge clk_i);
    chk_msg(m, key_of(f, 6'h1), ei, eq, ee);
  endtask
  task end_sim;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ====================
  // Main sequence
  initial
  begin
    {cyc, stb, we, n_dl_v, n_r} = '0;
    {adr, wdat, n_dl, ul_n, err_count, total_checks, cyc_n} = '0;
    sel = 4'hf;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(REG_CTRL, 32'h1);
    rd_chk(REG_DEADLINE, 32'h1000);
    rd_chk(REG_CELL_MAP + 8'h04, 32'h0);
    wb(1'b1, 8'h18, 32'hffff_ffff);
    rd_chk(8'h18, 32'h0);
    wb(1'b1, REG_DEADLINE, 32'h32);
    rd_chk(REG_DEADLINE, 32'h32);
    wb(1'b1, REG_DL_CELL, 32'h1);
    wb(1'b1, REG_UL_CELL, 32'h1);
    wb(1'b1, REG_CELL_MAP, 32'h1);
    dl_case(32'h1, 32'h1, 2'b11);
    dl_case(32'h1, 32'h2, 2'b01);
    dl_case(32'h3, 32'h1, 2'b01);
    ul_case(1, 1, 1, 0, 0, 16'h64, 16'h17, 16'hfffb, 16'hfff9,
            16'h7b, 16'hfff4, 0, 8'h10);
    ul_case(1, 1, 1, 0, 0, 16'h7530, 16'h7530, 16'h8ad0, 16'h8ad0,
            16'h7fff, 16'h8000, 0, 8'h20);
    ul_case(5, 1, 1, 1, 2, 16'h64, 16'h32, 16'h8, 16'hfff8,
            16'h64, 16'hfffc, 2, 8'h30);
    ul_case(1, 2, 0, 0, 0, 16'h7, 16'h0, 16'h9, 16'h0,
            16'h7, 16'h9, 0, 8'h40);
    ul_case(3, 1, 2, 0, 0, 16'ha, 16'h14, 16'h1, 16'h2,
            16'h1e, 16'h3, 0, 8'h50);
    ul_case(7, 1, 2, 1, 3, 16'h10, 16'h4, 16'hfffe, 16'h2,
            16'h12, 16'hffff, 1, 8'h58);
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b0, REG_TIMEOUTS, 32'h0);
    t = rd;
    chk(rd, 32'h0);
    m = ul_n / 4;
    fork
      ru.send(0, key_of(8'h60, 6'h1), 0, 16'h11, 16'h22, 1'b0);
      ru.send(1, key_of(8'h60, 6'h2), 0, 16'h33, 16'h44, 1'b0);
    join
    while (ul_n < 4 * m + 8) @(posedge clk_i);
    chk_msg(m, key_of(8'h60, 6'h1), 16'h11, 16'h22, 0);
    chk_msg(m + 1, key_of(8'h60, 6'h2), 16'h33, 16'h44, 0);
    rd_chk(REG_TIMEOUTS, t + 2);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[7:0], SEQ_W'(ul_got[0].seq_id + ul_n / 4));
    end_sim();
  end
endmodule

bind fhcc_core fhcc_monitor #(.N_PORTS(N_PORTS)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .north_dl_i(north_dl_i),
  .north_dl_valid_i(north_dl_valid_i),
  .north_dl_ready_o(north_dl_ready_o), .south_dl_o(south_dl_o),
  .south_dl_valid_o(south_dl_valid_o),
  .south_dl_ready_i(south_dl_ready_i),
  .south_ul_ready_o(south_ul_ready_o), .north_ul_o(north_ul_o),
  .north_ul_valid_o(north_ul_valid_o),
  .north_ul_ready_i(north_ul_ready_i));
